// *** hdl/sscp_defs.svh ***
`ifndef SSCP_DEFS_SVH
`define SSCP_DEFS_SVH

// Register offsets of the composite map.
`define SSCP_ADDR_ALARM    7'h00
`define SSCP_ADDR_TX_CTRL  7'h01
`define SSCP_ADDR_CODEC    7'h02
`define SSCP_ADDR_RXCLK    7'h03
`define SSCP_ADDR_RATE     7'h04
`define SSCP_ADDR_SPARE    7'h05
`define SSCP_ADDR_ATT_CFG  7'h06
`define SSCP_ADDR_ATT_FIFO 7'h07
`define SSCP_ADDR_CH1_CFG  7'h0E
`define SSCP_ADDR_CH2_CFG  7'h16
`define SSCP_ADDR_LIU_LAST 7'h04

// Reset value and field positions.
`define SSCP_REG_RESET     7'h00
`define SSCP_BIT_RCLK_A    0
`define SSCP_BIT_RCLK_B    1
`define SSCP_BIT_TX_INV    2
`define SSCP_BIT_CLOCK_EDGE_SELECT     1
`define SSCP_ATT_CFG_MASK  7'h5F

// Serial frame: read flag, 7 address bits, 8 data bits, MSB first.
`define SSCP_CNT_ADDR_DONE 4'h7
`define SSCP_CNT_LAST      4'hF

`endif

// *** hdl/sscp_pkg.sv ***
package sscp_pkg;

    typedef logic [6:0] sscp_reg_t;

    typedef struct packed {
        sscp_reg_t tx_ctrl;
        sscp_reg_t codec;
        sscp_reg_t rxclk;
        sscp_reg_t rate;
        sscp_reg_t att_cfg;
    } sscp_cfg_t;

    typedef struct packed {
        logic [4:0] alarm;
        logic       fifo_limit;
    } sscp_stat_t;

    typedef struct packed {
        logic [6:0] addr;
        sscp_reg_t  data;
    } sscp_wr_t;

    typedef struct packed {
        logic pos;
        logic neg;
        logic clk;
    } sscp_rail_t;

endpackage

// *** hdl/sscp_top.sv ***
// Contract
// - Shared reset low clears line unit and attenuator registers together.
// - Both serial outputs share one return line; addressed device drives.
// - Attenuator on channel 0 answers reads only at 0x06 and 0x07.
// - Attenuator floats its output on reads of any other address.
// - Line unit bits outside 0x00 to 0x04 read as zero.
// - Line unit never floats; drives low outside its own range.
// - Recovered rails change on rising edge of recovered clocks by default.
// - Transmit rails are sampled on falling transmit clock by default.
// - Channel 0 attenuator ignores writes to 0x0E and 0x16.
`include "sscp_defs.svh"

module sscp_top (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       shared_reset_n_i,
    input  wire logic       shared_select_n_i,
    input  wire logic       shared_serial_clock_i,
    input  wire logic       shared_serial_in_i,
    output logic            serial_data_out_o,
    output logic            att_serial_out_o,
    output logic            att_serial_oe_n_o,
    input  wire logic [4:0] line_alarm_i,
    input  wire logic       att_fifo_limit_i,
    input  wire logic       rec_clock_i,
    input  wire logic       rec_pos_i,
    input  wire logic       rec_neg_i,
    output logic            recovered_clock_a_o,
    output logic            recovered_clock_b_o,
    output logic            recv_pos_rail_o,
    output logic            recv_neg_rail_o,
    input  wire logic       tx_clock_i,
    input  wire logic       tx_pos_rail_i,
    input  wire logic       tx_neg_rail_i,
    output logic            tx_line_pos_o,
    output logic            tx_line_neg_o,
    output logic [6:0]      attenuator_config_o
);

    // ---------------- Serial clock domain ----------------
    logic [3:0]           cnt_r;
    logic [3:0]           cnt_nxt;
    logic [14:0]          sh_r;
    logic [14:0]          sh_nxt;
    logic                 rd_r;
    logic                 rd_nxt;
    logic                 att_sel_r;
    logic                 att_sel_nxt;
    logic [7:0]           rdw_r;
    logic [7:0]           rdw_nxt;
    logic                 liu_out_nxt;
    logic                 att_out_nxt;
    logic                 att_oe_n_nxt;
    logic                 wr_pend_r;
    logic                 wr_pend_nxt;
    sscp_pkg::sscp_wr_t   wr_hold_r;
    sscp_pkg::sscp_wr_t   wr_hold_nxt;
    sscp_pkg::sscp_cfg_t  cfg_r;
    sscp_pkg::sscp_cfg_t  cfg_l1_r;
    sscp_pkg::sscp_cfg_t  cfg_l2_r;
    sscp_pkg::sscp_stat_t st_l1_r;
    sscp_pkg::sscp_stat_t st_l2_r;
    logic [6:0]           frame_addr;
    logic                 frame_rd;
    logic                 att_hit;
    logic [6:0]           rd_val;

    assign frame_addr = {sh_r[5:0], shared_serial_in_i};
    assign frame_rd   = sh_r[6];
    assign att_hit    = (frame_addr == `SSCP_ADDR_ATT_CFG) ||
                        (frame_addr == `SSCP_ADDR_ATT_FIFO);

    always_comb begin
        unique case (frame_addr)
            `SSCP_ADDR_ALARM:    rd_val = {2'h0, st_l2_r.alarm};
            `SSCP_ADDR_TX_CTRL:  rd_val = cfg_l2_r.tx_ctrl;
            `SSCP_ADDR_CODEC:    rd_val = cfg_l2_r.codec;
            `SSCP_ADDR_RXCLK:    rd_val = cfg_l2_r.rxclk;
            `SSCP_ADDR_RATE:     rd_val = cfg_l2_r.rate;
            `SSCP_ADDR_ATT_CFG:  rd_val = cfg_l2_r.att_cfg;
            `SSCP_ADDR_ATT_FIFO: rd_val = {6'h00, st_l2_r.fifo_limit};
            default:             rd_val = `SSCP_REG_RESET;
        endcase
    end

    always_comb begin
        cnt_nxt      = (cnt_r == `SSCP_CNT_LAST) ? cnt_r : cnt_r + 4'h1;
        sh_nxt       = {sh_r[13:0], shared_serial_in_i};
        rd_nxt       = rd_r;
        att_sel_nxt  = att_sel_r;
        rdw_nxt      = {rdw_r[6:0], 1'b0};
        wr_pend_nxt  = wr_pend_r;
        wr_hold_nxt  = wr_hold_r;
        liu_out_nxt  = 1'b0;
        att_out_nxt  = rdw_r[6];
        att_oe_n_nxt = att_serial_oe_n_o;
        if (cnt_r == `SSCP_CNT_ADDR_DONE) begin
            rd_nxt       = frame_rd;
            att_sel_nxt  = att_hit;
            rdw_nxt      = {1'b0, rd_val};
            att_out_nxt  = 1'b0;
            att_oe_n_nxt = !(frame_rd && att_hit);
        end else if (cnt_r == `SSCP_CNT_LAST) begin
            // The sixteenth edge brings the last data bit. The word is
            // taken once, so extra edges of an over-long frame change nothing.
            att_oe_n_nxt = 1'b1;
            if (!rd_r && !wr_pend_r) begin
                wr_pend_nxt = 1'b1;
                wr_hold_nxt = '{addr: sh_r[13:7],
                                data: {sh_r[5:0], shared_serial_in_i}};
            end
        end else if (cnt_r > `SSCP_CNT_ADDR_DONE) begin
            // The line unit shows zeros while the attenuator answers.
            liu_out_nxt = rd_r && !att_sel_r && rdw_r[6];
        end
    end

    // The select pin clears the frame state, since the serial clock
    // stands still between frames and cannot do so itself.
    always_ff @(posedge shared_serial_clock_i or posedge shared_select_n_i)
    begin
        if (shared_select_n_i) begin
            cnt_r             <= 4'h0;
            sh_r              <= 15'h0000;
            rd_r              <= 1'b0;
            att_sel_r         <= 1'b0;
            rdw_r             <= 8'h00;
            wr_pend_r         <= 1'b0;
            serial_data_out_o <= 1'b0;
            att_serial_out_o  <= 1'b0;
            att_serial_oe_n_o <= 1'b1;
        end else begin
            cnt_r             <= cnt_nxt;
            sh_r              <= sh_nxt;
            rd_r              <= rd_nxt;
            att_sel_r         <= att_sel_nxt;
            rdw_r             <= rdw_nxt;
            wr_pend_r         <= wr_pend_nxt;
            serial_data_out_o <= liu_out_nxt;
            att_serial_out_o  <= att_out_nxt;
            att_serial_oe_n_o <= att_oe_n_nxt;
        end
    end

    // The write word and the configuration mirror outlive the frame.
    // The mirror is quasi-static: a write only moves the configuration a few
    // system clocks after a frame's last edge, while the serial clock
    // stands still, so a host that keeps the frame spacing reads no torn word.
    always_ff @(posedge shared_serial_clock_i) begin
        wr_hold_r <= wr_hold_nxt;
        cfg_l1_r  <= cfg_r;
        cfg_l2_r  <= cfg_l1_r;
        st_l1_r   <= '{alarm: line_alarm_i, fifo_limit: att_fifo_limit_i};
        st_l2_r   <= st_l1_r;
    end

    sequence att_read_start;
        cnt_r == `SSCP_CNT_ADDR_DONE && frame_rd;
    endsequence

    att_answer_a: assert property (@(posedge shared_serial_clock_i)
        disable iff (shared_select_n_i)
        att_read_start ##0 att_hit |=> !att_serial_oe_n_o [*8])
        else $error("attenuator did not drive its own register read");
    att_float_a: assert property (@(posedge shared_serial_clock_i)
        disable iff (shared_select_n_i)
        att_read_start ##0 !att_hit |=> att_serial_oe_n_o [*8])
        else $error("attenuator drove a foreign register read");
    liu_zero_a: assert property (@(posedge shared_serial_clock_i)
        disable iff (shared_select_n_i)
        att_read_start ##0 (frame_addr > `SSCP_ADDR_LIU_LAST)
        |=> !serial_data_out_o [*8])
        else $error("line unit read outside its range was not zero");
    return_owner_a: assert property (@(posedge shared_serial_clock_i)
        disable iff (shared_select_n_i)
        !att_serial_oe_n_o |-> att_sel_r && !serial_data_out_o)
        else $error("shared return line driven by both ends");
    att_quiet_a: assert property (@(posedge shared_serial_clock_i)
        disable iff (shared_select_n_i)
        cnt_r == `SSCP_CNT_ADDR_DONE && !frame_rd |=> att_serial_oe_n_o [*8])
        else $error("attenuator drove the line during a write");

    // ---------------- System clock domain ----------------
    logic                sreset_s1_r;
    logic                sreset_s2_r;
    logic [2:0]          wr_sync_r;
    sscp_pkg::sscp_cfg_t cfg_nxt;
    sscp_pkg::sscp_rail_t rx_s1_r;
    sscp_pkg::sscp_rail_t rx_s2_r;
    sscp_pkg::sscp_rail_t tx_s1_r;
    sscp_pkg::sscp_rail_t tx_s2_r;
    logic                rclk_prev_r;
    logic                tx_clock_prev_r;
    logic                wr_ev;
    logic                rclk_rise;
    logic                tx_clock_eff;
    logic                tx_clock_fall;
    logic                recv_pos_rail_nxt;
    logic                recv_neg_rail_nxt;
    logic                tpos_nxt;
    logic                tneg_nxt;

    // The pending level stands until select rises and only its rising
    // edge counts, so each write frame lands once. A host that raises
    // select within one system clock of the last edge can lose the write.
    assign wr_ev     = wr_sync_r[1] && !wr_sync_r[2];
    assign rclk_rise = rx_s2_r.clk && !rclk_prev_r;
    assign tx_clock_eff  = tx_s2_r.clk ^ cfg_r.tx_ctrl[`SSCP_BIT_TX_INV];
    assign tx_clock_fall = tx_clock_prev_r && !tx_clock_eff;

    always_comb begin
        cfg_nxt = cfg_r;
        if (!sreset_s2_r) begin
            cfg_nxt = '0;
        end else if (wr_ev) begin
            // Other channels' addresses and read-only ones fall through.
            unique case (wr_hold_r.addr)
                `SSCP_ADDR_TX_CTRL: cfg_nxt.tx_ctrl = wr_hold_r.data;
                `SSCP_ADDR_CODEC:   cfg_nxt.codec   = wr_hold_r.data;
                `SSCP_ADDR_RXCLK:   cfg_nxt.rxclk   = wr_hold_r.data;
                `SSCP_ADDR_RATE:    cfg_nxt.rate    = wr_hold_r.data;
                `SSCP_ADDR_ATT_CFG:
                    cfg_nxt.att_cfg = wr_hold_r.data & `SSCP_ATT_CFG_MASK;
                default:            cfg_nxt = cfg_r;
            endcase
        end
    end

    always_comb begin
        recv_pos_rail_nxt = rclk_rise ? rx_s2_r.pos : recv_pos_rail_o;
        recv_neg_rail_nxt = rclk_rise ? rx_s2_r.neg : recv_neg_rail_o;
        tpos_nxt = tx_clock_fall ? tx_s2_r.pos : tx_line_pos_o;
        tneg_nxt = tx_clock_fall ? tx_s2_r.neg : tx_line_neg_o;
    end

    always_ff @(posedge clk_i) begin
        sreset_s1_r <= shared_reset_n_i;
        sreset_s2_r <= sreset_s1_r;
        rx_s1_r     <= '{pos: rec_pos_i, neg: rec_neg_i, clk: rec_clock_i};
        rx_s2_r     <= rx_s1_r;
        tx_s1_r     <= '{pos: tx_pos_rail_i, neg: tx_neg_rail_i,
                         clk: tx_clock_i};
        tx_s2_r     <= tx_s1_r;
        if (!rst_n_i) begin
            wr_sync_r           <= 3'h0;
            cfg_r               <= '0;
            rclk_prev_r         <= 1'b0;
            tx_clock_prev_r         <= 1'b0;
            recv_pos_rail_o     <= 1'b0;
            recv_neg_rail_o     <= 1'b0;
            recovered_clock_a_o <= 1'b0;
            recovered_clock_b_o <= 1'b0;
            tx_line_pos_o       <= 1'b0;
            tx_line_neg_o       <= 1'b0;
            attenuator_config_o <= `SSCP_REG_RESET;
        end else begin
            wr_sync_r           <= {wr_sync_r[1:0], wr_pend_r};
            cfg_r               <= cfg_nxt;
            rclk_prev_r         <= rx_s2_r.clk;
            tx_clock_prev_r         <= tx_clock_eff;
            recv_pos_rail_o     <= recv_pos_rail_nxt;
            recv_neg_rail_o     <= recv_neg_rail_nxt;
            recovered_clock_a_o <= rx_s2_r.clk ^
                                   cfg_r.rxclk[`SSCP_BIT_RCLK_A];
            recovered_clock_b_o <= rx_s2_r.clk ^
                                   cfg_r.rxclk[`SSCP_BIT_RCLK_B];
            tx_line_pos_o       <= tpos_nxt;
            tx_line_neg_o       <= tneg_nxt;
            attenuator_config_o <= cfg_r.att_cfg;
        end
    end

    shared_reset_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        !sreset_s2_r |=> cfg_r == '0 ##1 attenuator_config_o == 7'h00)
        else $error("shared reset left a register set");
    foreign_write_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        wr_ev && sreset_s2_r &&
        (wr_hold_r.addr == `SSCP_ADDR_CH1_CFG ||
         wr_hold_r.addr == `SSCP_ADDR_CH2_CFG) |=> $stable(cfg_r))
        else $error("write to another channel changed state");
    rx_launch_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        rclk_rise && !cfg_r.rxclk[`SSCP_BIT_RCLK_A]
        |=> recovered_clock_a_o && recv_pos_rail_o == $past(rx_s2_r.pos))
        else $error("recovered data not launched on rising clock");
    rx_hold_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        !rclk_rise |=> $stable(recv_pos_rail_o) && $stable(recv_neg_rail_o))
        else $error("recovered data moved away from clock edge");
    tx_sample_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        tx_clock_fall |=> tx_line_pos_o == $past(tx_s2_r.pos) &&
                      tx_line_neg_o == $past(tx_s2_r.neg))
        else $error("transmit rails not sampled on falling clock");

endmodule

// *** sim/sscp_host_model.sv ***
module sscp_host_model (
    output logic      select_n_o,
    output logic      sclk_o,
    output logic      sdi_o,
    input  wire logic sdo_i
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam int HALF = 24;

    // The serial clock stands still low between frames. Select starts
    // low and rises once, since only its rising edge clears the frame logic.
    initial begin
        select_n_o = 1'b0;
        sclk_o     = 1'b0;
        sdi_o      = 1'b0;
        #1 select_n_o = 1'b1;
    end

    task automatic xfer(input logic rd, input logic [6:0] addr,
                        input logic [7:0] wdata, output logic [7:0] rdata);
        logic [15:0] frame;
        frame = {rd, addr, wdata};
        rdata = 8'h00;
        select_n_o = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi_o = frame[i];
            #HALF sclk_o = 1'b1;
            #HALF if (i <= 8 && i >= 1) rdata = {rdata[6:0], sdo_i};
            sclk_o = 1'b0;
        end
        #HALF select_n_o = 1'b1;
        // A released data line must not keep showing its last bit.
        sdi_o = ~sdi_o;
        #(2 * HALF);
    endtask
endmodule

// *** sim/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clk_i = 1'b0, rst_n = 1'b0, sh_rst_n = 1'b0;
    logic       sel_n, sclk, sdi, lu_sdo, att_sdo, att_oe_n, sdo_wire;
    logic [4:0] alarm = 5'h00;
    logic       fifo_lim = 1'b0, rec_clk = 1'b0, rec_pos = 1'b0;
    logic       rec_neg = 1'b0, tx_clk = 1'b0, tx_pos = 1'b0, tx_neg = 1'b0;
    logic       rclk_a, rclk_b, recv_pos_rail, recv_neg_rail, tx_lp, tx_ln;
    logic [6:0] att_cfg;
    logic       oe_seen = 1'b0;
    logic       lu_seen = 1'b0;
    int         failures = 0;
    int         checks = 0;

    always #2.5 clk_i = ~clk_i;

    // The line unit reaches the shared wire through a resistor, so the
    // attenuator wins whenever it drives.
    assign sdo_wire = (att_oe_n === 1'b0) ? att_sdo : lu_sdo;

    always @(posedge clk_i) if (att_oe_n === 1'b0) oe_seen <= 1'b1;
    always @(posedge clk_i) if (lu_sdo !== 1'b0) lu_seen <= 1'b1;

    sscp_host_model i_host (.select_n_o(sel_n), .sclk_o(sclk),
                            .sdi_o(sdi), .sdo_i(sdo_wire));

    sscp_top i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n), .shared_reset_n_i(sh_rst_n),
        .shared_select_n_i(sel_n), .shared_serial_clock_i(sclk),
        .shared_serial_in_i(sdi), .serial_data_out_o(lu_sdo),
        .att_serial_out_o(att_sdo), .att_serial_oe_n_o(att_oe_n),
        .line_alarm_i(alarm), .att_fifo_limit_i(fifo_lim),
        .rec_clock_i(rec_clk), .rec_pos_i(rec_pos), .rec_neg_i(rec_neg),
        .recovered_clock_a_o(rclk_a), .recovered_clock_b_o(rclk_b),
        .recv_pos_rail_o(recv_pos_rail), .recv_neg_rail_o(recv_neg_rail),
        .tx_clock_i(tx_clk), .tx_pos_rail_i(tx_pos), .tx_neg_rail_i(tx_neg),
        .tx_line_pos_o(tx_lp), .tx_line_neg_o(tx_ln),
        .attenuator_config_o(att_cfg));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (failures == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // The dummy read gives the serial-side mirror its sync edges.
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        i_host.xfer(1'b0, a, d, r);
        i_host.xfer(1'b1, 7'h05, 8'h00, r);
    endtask

    task automatic rdc(input logic [6:0] a, input logic [7:0] e,
                       input logic oe);
        logic [7:0] r;
        oe_seen = 1'b0;
        lu_seen = 1'b0;
        i_host.xfer(1'b1, a, 8'h00, r);
        chk(r, e);
        chk({7'h00, oe_seen}, {7'h00, oe});
        chk({7'h00, lu_sdo}, 8'h00);
        chk({7'h00, lu_seen}, {7'h00, (a <= 7'h04) && (e != 8'h00)});
    endtask

    task automatic t_regs();
        logic [6:0] a[5] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h06};
        logic [7:0] v[5] = '{8'h1F, 8'h0F, 8'h1F, 8'h0F, 8'h7F};
        logic [7:0] e[5] = '{8'h1F, 8'h0F, 8'h1F, 8'h0F, 8'h5F};
        for (int i = 0; i < 5; i++) wr(a[i], v[i]);
        for (int i = 0; i < 5; i++) rdc(a[i], e[i], a[i] == 7'h06);
        chk({1'b0, att_cfg}, 8'h5F);
    endtask

    task automatic t_reset();
        @(posedge clk_i) sh_rst_n <= 1'b0;
        repeat (4) @(posedge clk_i);
        sh_rst_n <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk({1'b0, att_cfg}, 8'h00);
        for (int i = 1; i <= 4; i++) rdc(7'(i), 8'h00, 1'b0);
        rdc(7'h06, 8'h00, 1'b1);
    endtask

    task automatic t_refused();
        logic [6:0] bad[5] = '{7'h0E, 7'h16, 7'h00, 7'h07, 7'h05};
        logic [6:0] far[5] = '{7'h05, 7'h0E, 7'h0F, 7'h16, 7'h7F};
        @(posedge clk_i) alarm <= 5'h15;
        fifo_lim <= 1'b1;
        wr(7'h06, 8'h02);
        for (int i = 0; i < 5; i++) wr(bad[i], 8'h7F);
        rdc(7'h06, 8'h02, 1'b1);
        rdc(7'h07, 8'h01, 1'b1);
        rdc(7'h00, 8'h15, 1'b0);
        for (int i = 0; i < 5; i++) rdc(far[i], 8'h00, 1'b0);
    endtask

    task automatic t_rails();
        wr(7'h03, 8'h00);
        wr(7'h01, 8'h00);
        chk({1'b0, att_cfg}, 8'h02);
        @(posedge clk_i) rec_pos <= 1'b1;
        repeat (8) @(posedge clk_i);
        rec_clk <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk({4'h0, rclk_a, rclk_b, recv_pos_rail, recv_neg_rail}, 8'h0E);
        rec_pos <= 1'b0;
        repeat (8) @(posedge clk_i);
        rec_clk <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk({4'h0, rclk_a, rclk_b, recv_pos_rail, recv_neg_rail}, 8'h02);
        wr(7'h03, 8'h03);
        chk({6'h00, rclk_a, rclk_b}, 8'h03);
        @(posedge clk_i) {tx_pos, tx_neg, tx_clk} <= 3'b111;
        repeat (8) @(posedge clk_i);
        chk({6'h00, tx_lp, tx_ln}, 8'h00);
        tx_clk <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk({6'h00, tx_lp, tx_ln}, 8'h03);
        wr(7'h01, 8'h04);
        @(posedge clk_i) tx_pos <= 1'b0;
        repeat (8) @(posedge clk_i);
        tx_clk <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk({6'h00, tx_lp, tx_ln}, 8'h01);
        wr(7'h01, 8'h00);
        wr(7'h03, 8'h00);
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        rst_n <= 1'b1;
        sh_rst_n <= 1'b1;
        repeat (4) @(posedge clk_i);
        t_regs();
        t_reset();
        t_refused();
        t_rails();
        end_sim();
    end

    // About fifty frames of roughly a microsecond each fit well inside.
    initial begin
        #200000;
        failures++;
        end_sim();
    end
endmodule
